// [src/rxagc_top.sv]
// Receive gain loop: sequences update periods, steers amplifier gain,
// reports signal strength and freeze events.
// Assumes every input is produced on clk; settings change only between
// receive sessions or are tolerated mid-period.
`timescale 1ns/1ps
`include "rxagc_cfg.svh"
module rxagc_top #(
	// Right shift of every microsecond wait, to shorten simulations
	parameter int WAIT_SHIFT = 0
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// Receiver state and samples
	input  wire logic               rx_active,
	input  wire logic               sample_valid,
	input  wire logic signed [12:0] i_unf,
	input  wire logic signed [12:0] q_unf,
	input  wire logic signed [12:0] i_flt,
	input  wire logic signed [12:0] q_flt,
	// Software settings
	input  wire logic               gain_ref_select,
	input  wire logic               gain_loop_enable,
	input  wire logic [1:0]         averaging_length,
	input  wire logic               gain_freeze_control,
	input  wire logic [2:0]         gain_target_level,
	input  wire logic [3:0]         rx_sample_rate_code,
	input  wire logic [3:0]         rx_bandwidth_code,
	input  wire logic               ext_amp_bypass_enable,
	input  wire logic [1:0]         ext_amp_gain_mapping,
	input  wire logic [4:0]         sw_gain_word,
	// Baseband core
	input  wire logic               bb_enable,
	input  wire logic               bb_freeze_req,
	// Status
	output logic [4:0]              gain_word_field,
	output logic                    gain_freeze_status,
	output logic                    gain_hold_irq,
	output logic                    gain_release_irq,
	output logic [7:0]              signal_strength_field,
	output logic                    signal_strength_valid,
	// Amplifier control
	output logic [4:0]              amp_gain_word,
	output logic                    ext_amp_on
);
	rxagc_meas_if meas ();

	rxagc_pkg::rxagc_state_t state;
	rxagc_pkg::rxagc_state_t next_state;
	logic [15:0] wait_cnt;
	logic [3:0]  sr;
	logic [3:0]  sr_cap;
	logic [7:0]  tw_q;
	logic [15:0] tw_cycles;
	logic [15:0] first_cycles;
	rxagc_pkg::rxagc_word_t gmax;
	logic        freeze;
	logic        bb_frz_d;
	rxagc_pkg::rxagc_word_t next_word;
	logic signed [6:0] dev;
	logic signed [6:0] wsum;
	rxagc_pkg::rxagc_word_t ext_steps;
	logic signed [9:0] rssi_raw;
	logic signed [9:0] rssi_clip;

	rxagc_power u_power (
		.clk          (clk),
		.rst          (rst),
		.sample_valid (sample_valid),
		.i_unf        (i_unf),
		.q_unf        (q_unf),
		.i_flt        (i_flt),
		.q_flt        (q_flt),
		.m            (meas.meas)
	);

	// Unknown rate codes fall back to the 4 MHz setting
	always_comb begin
		case (rx_sample_rate_code)
			4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hA:
				sr = rx_sample_rate_code;
			default:
				sr = `AGC_SR_DEFAULT;
		endcase
	end

	// Settling wait grows with the post filter group delay
	always_comb begin
		case ({gain_ref_select, sr})
			5'h11: tw_q = 8'(`AGC_TW1_SR1);
			5'h12: tw_q = 8'(`AGC_TW1_SR2);
			5'h13: tw_q = 8'(`AGC_TW1_SR3);
			5'h14: tw_q = 8'(`AGC_TW1_SR4);
			5'h15: tw_q = 8'(`AGC_TW1_SR5);
			5'h16: tw_q = 8'(`AGC_TW1_SR6);
			5'h18: tw_q = 8'(`AGC_TW1_SR8);
			5'h1A: tw_q = 8'(`AGC_TW1_SR10);
			5'h01: tw_q = 8'(`AGC_TW0_SR1);
			5'h02: tw_q = 8'(`AGC_TW0_SR2);
			5'h03: tw_q = 8'(`AGC_TW0_SR3);
			5'h04: tw_q = 8'(`AGC_TW0_SR4);
			5'h05: tw_q = 8'(`AGC_TW0_SR5);
			5'h06: tw_q = 8'(`AGC_TW0_SR6);
			5'h08: tw_q = 8'(`AGC_TW0_SR8);
			5'h0A: tw_q = 8'(`AGC_TW0_SR10);
			default: tw_q = 8'(`AGC_TW0_SR1);
		endcase
	end

	// Waits in clock cycles; least times round up
	always_comb begin
		tw_cycles = 16'(((32'(tw_q) * `AGC_CLK_MHZ + `AGC_QUARTERS - 1)
			/ `AGC_QUARTERS) >> WAIT_SHIFT);
		first_cycles = 16'(((32'(sr) * `AGC_FIRST_WAIT_NS * `AGC_CLK_MHZ
			+ `AGC_NS_PER_US - 1) / `AGC_NS_PER_US) >> WAIT_SHIFT);
	end

	always_comb begin
		if (rx_bandwidth_code <= `AGC_BW_LO_LAST)
			gmax = `AGC_GMAX_LO;
		else if (rx_bandwidth_code <= `AGC_BW_MID_LAST)
			gmax = `AGC_GMAX_MID;
		else
			gmax = `AGC_GMAX_HI;
	end

	assign freeze = gain_freeze_control || (bb_enable && bb_freeze_req);

	// Sequencer
	always_comb begin
		next_state = state;
		case (state)
			rxagc_pkg::ST_IDLE:
				if (rx_active)
					next_state = rxagc_pkg::ST_FIRST;
			rxagc_pkg::ST_FIRST:
				if (wait_cnt == 16'h0000)
					next_state = rxagc_pkg::ST_SETTLE;
			rxagc_pkg::ST_SETTLE:
				if (wait_cnt == 16'h0000)
					next_state = rxagc_pkg::ST_AVG;
			rxagc_pkg::ST_AVG:
				// A run cut short by leaving receive may end just as
				// the next one starts; that stale result is ignored
				if (meas.done && !meas.start)
					next_state = rxagc_pkg::ST_UPDATE;
			rxagc_pkg::ST_UPDATE:
				next_state = rxagc_pkg::ST_SETTLE;
			default:
				next_state = rxagc_pkg::ST_IDLE;
		endcase
		if (!rx_active)
			next_state = rxagc_pkg::ST_IDLE;
	end

	always_ff @(posedge clk) begin
		if (rst)
			state <= rxagc_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	// Wait counter loaded on entry to each timed state
	always_ff @(posedge clk) begin
		if (rst)
			wait_cnt <= 16'h0000;
		else if (next_state == rxagc_pkg::ST_FIRST
			&& state != rxagc_pkg::ST_FIRST)
			wait_cnt <= (first_cycles == 16'h0000) ? 16'h0000
				: first_cycles - 16'h0001;
		else if (next_state == rxagc_pkg::ST_SETTLE
			&& state != rxagc_pkg::ST_SETTLE)
			wait_cnt <= (tw_cycles == 16'h0000) ? 16'h0000
				: tw_cycles - 16'h0001;
		else if (wait_cnt != 16'h0000)
			wait_cnt <= wait_cnt - 16'h0001;
	end

	// Averager start, parameters caught at start
	always_ff @(posedge clk) begin
		if (rst) begin
			meas.start   <= 1'b0;
			meas.ref_sel <= 1'b0;
			meas.avg_len <= 2'h0;
			sr_cap       <= `AGC_SR_DEFAULT;
		end else begin
			meas.start <= state == rxagc_pkg::ST_SETTLE
				&& next_state == rxagc_pkg::ST_AVG;
			if (state == rxagc_pkg::ST_SETTLE
				&& next_state == rxagc_pkg::ST_AVG) begin
				meas.ref_sel <= gain_ref_select;
				meas.avg_len <= averaging_length;
				sr_cap       <= sr;
			end
		end
	end

	// Deviation in 3 dB steps; one log2 step is about 3 dB of power
	always_comb begin
		dev = 7'(signed'({2'b00, meas.pwr_log}))
			- (`AGC_TGT_TOP - 7'(signed'({4'h0, gain_target_level})));
		wsum = 7'(signed'({2'b00, gain_word_field})) - dev;
		if (wsum < 7'sh00)
			next_word = 5'h00;
		else if (wsum > 7'(signed'({2'b00, gmax})))
			next_word = gmax;
		else
			next_word = 5'(wsum);
	end

	// Gain word: loop result at period end, else software value
	always_ff @(posedge clk) begin
		if (rst)
			gain_word_field <= 5'h00;
		else if (!gain_loop_enable) begin
			if (!freeze)
				gain_word_field <= (sw_gain_word > gmax) ? gmax
					: sw_gain_word;
		end else if (state == rxagc_pkg::ST_UPDATE && !freeze)
			gain_word_field <= next_word;
	end

	// Applied gain is held while frozen so the data path stays steady
	always_ff @(posedge clk) begin
		if (rst) begin
			amp_gain_word <= 5'h00;
			ext_amp_on    <= 1'b0;
		end else if (!freeze) begin
			if (!ext_amp_bypass_enable) begin
				amp_gain_word <= gain_word_field;
				ext_amp_on    <= 1'b1;
			end else if (gain_word_field > `AGC_BYP_THRESH) begin
				amp_gain_word <= gain_word_field - ext_steps;
				ext_amp_on    <= 1'b1;
			end else begin
				amp_gain_word <= gain_word_field;
				ext_amp_on    <= 1'b0;
			end
		end
	end

	always_comb begin
		case (ext_amp_gain_mapping)
			`AGC_MAP_9DB:  ext_steps = `AGC_STEPS_9DB;
			`AGC_MAP_12DB: ext_steps = `AGC_STEPS_12DB;
			default:       ext_steps = 5'h00;
		endcase
	end

	// Freeze status and baseband driven hold and release pulses
	always_ff @(posedge clk) begin
		if (rst) begin
			gain_freeze_status <= 1'b0;
			bb_frz_d           <= 1'b0;
			gain_hold_irq      <= 1'b0;
			gain_release_irq   <= 1'b0;
		end else begin
			gain_freeze_status <= freeze;
			bb_frz_d           <= bb_enable && bb_freeze_req;
			gain_hold_irq <= bb_enable && bb_freeze_req && !bb_frz_d;
			gain_release_irq <= !(bb_enable && bb_freeze_req)
				&& bb_frz_d;
		end
	end

	// Input power: measured level less applied gain, external gain counted
	always_comb begin
		rssi_raw = 10'sh003 * 10'(signed'({5'h00, meas.pwr_log}))
			- 10'sh003 * 10'(signed'({5'h00, amp_gain_word}))
			- 10'sh003 * 10'(signed'({5'h00, ext_on_steps()}))
			- `AGC_RSSI_OFS;
		if (rssi_raw < `AGC_RSSI_MIN)
			rssi_clip = `AGC_RSSI_MIN;
		else if (rssi_raw > `AGC_RSSI_MAX)
			rssi_clip = `AGC_RSSI_MAX;
		else
			rssi_clip = rssi_raw;
	end

	function automatic rxagc_pkg::rxagc_word_t ext_on_steps();
		return ext_amp_on ? ext_steps : 5'h00;
	endfunction

	// Strength valid only from the first finished period in receive
	always_ff @(posedge clk) begin
		if (rst) begin
			signal_strength_field <= `AGC_RSSI_INVALID;
			signal_strength_valid <= 1'b0;
		end else if (!rx_active) begin
			signal_strength_field <= `AGC_RSSI_INVALID;
			signal_strength_valid <= 1'b0;
		end else if (state == rxagc_pkg::ST_UPDATE) begin
			signal_strength_field <= 8'(rssi_clip);
			signal_strength_valid <= 1'b1;
		end
	end
endmodule

// [src/rxagc_cfg.svh]
// Constants of the receive gain loop and signal strength estimator.
// Assumes a 125 MHz system clock and a sample strobe from the front-end.
//
// Behaviour
// - Measure unfiltered or filtered variance per select bit
// - Unfiltered is pre-post-filter, filtered is post-filter output
// - Loop enabled drives gain toward zero deviation
// - Period is settling wait then magnitude averaging
// - Each period end stores new gain word
// - Gain word zero to max, 3dB per step
// - Max word 21, 22 or 23 by bandwidth
// - Freeze stops word update and gain application
// - Baseband freezes itself, status bit, hold/release pulses
// - Software target level sets the variance target
// - Loop disabled applies software gain word directly
// - Period follows select, rate and averaging lookup
// - Bypass mode maps high words, bypasses low ones
// - No bypass, loop includes external amplifier gain
// - Periods continue during freeze for strength estimate
// - Strength reads 127 without valid estimate
// - First strength after 8us times rate plus period
// - Measure and store only in receive state
`ifndef RXAGC_CFG_SVH
`define RXAGC_CFG_SVH

`define AGC_CLK_MHZ        125
`define AGC_FIRST_WAIT_NS  8000
`define AGC_NS_PER_US      1000
`define AGC_QUARTERS       4
`define AGC_AVG_BASE_SHIFT 3

// Settling wait in quarter microseconds, unfiltered reference
`define AGC_TW1_SR1  19
`define AGC_TW1_SR2  26
`define AGC_TW1_SR3  39
`define AGC_TW1_SR4  52
`define AGC_TW1_SR5  65
`define AGC_TW1_SR6  78
`define AGC_TW1_SR8  104
`define AGC_TW1_SR10 100
// Settling wait in quarter microseconds, filtered reference
`define AGC_TW0_SR1  27
`define AGC_TW0_SR2  42
`define AGC_TW0_SR3  63
`define AGC_TW0_SR4  84
`define AGC_TW0_SR5  105
`define AGC_TW0_SR6  126
`define AGC_TW0_SR8  128
`define AGC_TW0_SR10 180

`define AGC_SR_DEFAULT 4'h1
`define AGC_BW_LO_LAST  4'h5
`define AGC_BW_MID_LAST 4'h8
`define AGC_GMAX_LO  5'h15
`define AGC_GMAX_MID 5'h16
`define AGC_GMAX_HI  5'h17

`define AGC_BYP_THRESH 5'h11
`define AGC_MAP_9DB    2'h1
`define AGC_MAP_12DB   2'h2
`define AGC_STEPS_9DB  5'h03
`define AGC_STEPS_12DB 5'h04

// Target: log2 power the loop aims for, lowered by the target field
`define AGC_TGT_TOP 7'sh14
// Calibration offset from log2 power to dBm, arbitrary default
`define AGC_RSSI_OFS 10'sh069
`define AGC_RSSI_MIN 10'sh381
`define AGC_RSSI_MAX 10'sh004
`define AGC_RSSI_INVALID 8'h7F

`endif

// [src/rxagc_pkg.sv]
// Types shared by the gain loop modules.
// Assumes nothing of its surroundings.
package rxagc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FIRST,
		ST_SETTLE,
		ST_AVG,
		ST_UPDATE
	} rxagc_state_t;

	typedef logic [4:0] rxagc_word_t;
endpackage

// [src/rxagc_meas_if.sv]
// Carrier between the loop sequencer and the power averager.
// Assumes both ends run on the one system clock.
`timescale 1ns/1ps
interface rxagc_meas_if;
	logic                start;
	logic                ref_sel;
	logic [1:0]          avg_len;
	logic                done;
	rxagc_pkg::rxagc_word_t pwr_log;

	modport ctrl (output start, ref_sel, avg_len, input done, pwr_log);
	modport meas (input start, ref_sel, avg_len, output done, pwr_log);
endinterface

// [src/rxagc_power.sv]
// Averager of complex magnitude squared over 8, 16, 32 or 64 samples.
// Assumes samples and strobe come from logic on the same clock.
`timescale 1ns/1ps
`include "rxagc_cfg.svh"
module rxagc_power (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// Baseband samples
	input  wire logic               sample_valid,
	input  wire logic signed [12:0] i_unf,
	input  wire logic signed [12:0] q_unf,
	input  wire logic signed [12:0] i_flt,
	input  wire logic signed [12:0] q_flt,
	// Sequencer side
	rxagc_meas_if.meas              m
);
	logic        busy;
	logic [6:0]  cnt;
	logic [31:0] acc;
	logic        sel;
	logic [1:0]  len;
	logic signed [12:0] si;
	logic signed [12:0] sq;
	logic [31:0] mag;
	logic [31:0] sum;
	logic [31:0] mean;
	logic [6:0]  last;

	function automatic rxagc_pkg::rxagc_word_t log2f(input logic [31:0] v);
		rxagc_pkg::rxagc_word_t r;
		r = 5'h00;
		for (int k = 1; k < 32; k++) begin
			if (v[k])
				r = 5'(k);
		end
		return r;
	endfunction

	always_comb begin
		si = sel ? i_unf : i_flt;
		sq = sel ? q_unf : q_flt;
		mag = 32'(si * si) + 32'(sq * sq);
		sum = acc + mag;
		mean = sum >> (`AGC_AVG_BASE_SHIFT + len);
		last = 7'((8 << len) - 1);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			busy <= 1'b0;
			cnt  <= 7'h00;
			acc  <= 32'h0;
			sel  <= 1'b0;
			len  <= 2'h0;
		end else if (m.start) begin
			busy <= 1'b1;
			cnt  <= 7'h00;
			acc  <= 32'h0;
			sel  <= m.ref_sel;
			len  <= m.avg_len;
		end else if (busy && sample_valid) begin
			acc <= sum;
			cnt <= cnt + 7'h01;
			if (cnt == last)
				busy <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			m.done    <= 1'b0;
			m.pwr_log <= 5'h00;
		end else begin
			m.done <= busy && sample_valid && cnt == last && !m.start;
			if (busy && sample_valid && cnt == last)
				m.pwr_log <= log2f(mean);
		end
	end
endmodule

// [sim/rxagc_asserts.sv]
// Port-level checker of the receive gain loop top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module rxagc_asserts #(
	parameter int WAIT_SHIFT = 0
) (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// Settings and baseband
	input wire logic       rx_active,
	input wire logic       gain_loop_enable,
	input wire logic       gain_freeze_control,
	input wire logic [3:0] rx_bandwidth_code,
	input wire logic       ext_amp_bypass_enable,
	input wire logic [1:0] ext_amp_gain_mapping,
	input wire logic [4:0] sw_gain_word,
	input wire logic       bb_enable,
	input wire logic       bb_freeze_req,
	// Status and amplifier
	input wire logic [4:0] gain_word_field,
	input wire logic       gain_freeze_status,
	input wire logic       gain_hold_irq,
	input wire logic       gain_release_irq,
	input wire logic [7:0] signal_strength_field,
	input wire logic [4:0] amp_gain_word,
	input wire logic       ext_amp_on
);
	function automatic logic [4:0] gmax(logic [3:0] bw);
		return bw <= 4'h5 ? 5'h15 : (bw <= 4'h8 ? 5'h16 : 5'h17);
	endfunction

	function automatic logic [5:0] amp_of(logic [4:0] w, logic byp,
			logic [1:0] map);
		logic [4:0] st;
		st = map == 2'h1 ? 5'h03 : (map == 2'h2 ? 5'h04 : 5'h00);
		if (!byp)
			return {1'b1, w};
		return w > 5'h11 ? {1'b1, w - st} : {1'b0, w};
	endfunction

	logic       frz_in;
	logic [4:0] man_w;
	logic [5:0] amp_x;
	assign frz_in = gain_freeze_control | (bb_enable & bb_freeze_req);
	assign man_w = sw_gain_word > gmax(rx_bandwidth_code) ?
		gmax(rx_bandwidth_code) : sw_gain_word;
	assign amp_x = amp_of(gain_word_field, ext_amp_bypass_enable,
		ext_amp_gain_mapping);

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	chk_no_estimate: assert property (
		!rx_active |=> signal_strength_field == 8'h7F)
		else $error("strength not invalid outside receive");
	chk_strength_span: assert property (
		signal_strength_field != 8'h7F |->
		$signed(signal_strength_field) >= -127 &&
		$signed(signal_strength_field) <= 4)
		else $error("strength out of range");
	chk_gain_ceiling: assert property (
		$stable(rx_bandwidth_code) && rx_bandwidth_code <= 4'hB |->
		gain_word_field <= gmax(rx_bandwidth_code))
		else $error("gain word above maximum");
	chk_frozen_word: assert property (
		gain_freeze_status [*3] |->
		$stable(gain_word_field) && $stable(amp_gain_word))
		else $error("gain moved while frozen");
	chk_status_track: assert property (
		1'b1 |=> gain_freeze_status == $past(frz_in))
		else $error("freeze status wrong");
	chk_hold_edge: assert property (
		$rose(bb_freeze_req) && bb_enable && $past(bb_enable) |=>
		gain_hold_irq ##1 !gain_hold_irq)
		else $error("hold pulse wrong");
	chk_release_edge: assert property (
		$fell(bb_freeze_req) && bb_enable && $past(bb_enable) |=>
		gain_release_irq ##1 !gain_release_irq)
		else $error("release pulse wrong");
	chk_manual_word: assert property (
		!gain_loop_enable && !frz_in && !gain_freeze_status |=>
		gain_word_field == $past(man_w))
		else $error("manual gain word wrong");
	chk_amp_map: assert property (
		!frz_in && !gain_freeze_status &&
		$stable(ext_amp_bypass_enable) && $stable(ext_amp_gain_mapping)
		|=> {ext_amp_on, amp_gain_word} == $past(amp_x))
		else $error("amplifier mapping wrong");
endmodule

bind rxagc_top rxagc_asserts #(.WAIT_SHIFT(WAIT_SHIFT)) u_chk (
	.clk(clk), .rst(rst), .rx_active(rx_active),
	.gain_loop_enable(gain_loop_enable),
	.gain_freeze_control(gain_freeze_control),
	.rx_bandwidth_code(rx_bandwidth_code),
	.ext_amp_bypass_enable(ext_amp_bypass_enable),
	.ext_amp_gain_mapping(ext_amp_gain_mapping),
	.sw_gain_word(sw_gain_word), .bb_enable(bb_enable),
	.bb_freeze_req(bb_freeze_req), .gain_word_field(gain_word_field),
	.gain_freeze_status(gain_freeze_status),
	.gain_hold_irq(gain_hold_irq), .gain_release_irq(gain_release_irq),
	.signal_strength_field(signal_strength_field),
	.amp_gain_word(amp_gain_word), .ext_amp_on(ext_amp_on));

// [sim/rxagc_test.sv]
// Self-checking bench of the receive gain loop top module.
// Assumes shortened waits via WAIT_SHIFT and a 4 MHz sample strobe.
`timescale 1ns/1ps
module rxagc_test;
	localparam int WS = 4;
	localparam int SP = 31;
	// First wait, filtered settle wait, then all but one strobe
	localparam int LO = (1000 >> WS) + (((27 * 125 + 3) / 4) >> WS) + 7 * SP;
	localparam int HI = LO + SP + 20;
	// Sixteen-sample averages add eight strobe spacings
	localparam int LO2 = LO + 8 * SP;
	localparam int HI2 = HI + 8 * SP;
	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic               rx_active = 1'b0;
	logic               sample_valid = 1'b0;
	logic signed [12:0] amp_f = 13'sh0000;
	logic signed [12:0] amp_u = 13'sh0000;
	logic               gain_ref_select = 1'b0;
	logic               gain_loop_enable = 1'b0;
	logic               gain_freeze_control = 1'b0;
	logic               ext_amp_bypass_enable = 1'b0;
	logic [1:0]         ext_amp_gain_mapping = 2'h0;
	logic [1:0]         averaging_length = 2'h0;
	logic [2:0]         gain_target_level = 3'h0;
	logic [3:0]         rx_bandwidth_code = 4'hB;
	logic [4:0]         sw_gain_word = 5'h00;
	logic               bb_enable = 1'b0;
	logic               bb_freeze_req = 1'b0;
	logic [4:0]         gain_word_field, amp_gain_word, w0;
	logic               gain_freeze_status, gain_hold_irq;
	logic               gain_release_irq, signal_strength_valid, ext_amp_on;
	logic [7:0]         signal_strength_field, s0;
	int                 n_fail = 0, n_tests = 0, cycles = 0, strobe = 0;
	int                 lat;
	logic [3:0]         bws [3] = '{4'h5, 4'h8, 4'hB};
	logic [7:0]         gmx [3] = '{8'h15, 8'h16, 8'h17};
	logic               byp [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
	logic [1:0]         mp [4] = '{2'h1, 2'h2, 2'h1, 2'h2};
	logic [4:0]         wd [4] = '{5'h14, 5'h14, 5'h11, 5'h14};
	logic [7:0]         ea [4] = '{8'h31, 8'h30, 8'h11, 8'h34};

	rxagc_top #(.WAIT_SHIFT(WS)) u_dut (
		.clk(clk), .rst(rst), .rx_active(rx_active),
		.sample_valid(sample_valid), .i_unf(amp_u), .q_unf(amp_u),
		.i_flt(amp_f), .q_flt(amp_f), .gain_ref_select(gain_ref_select),
		.gain_loop_enable(gain_loop_enable),
		.averaging_length(averaging_length),
		.gain_freeze_control(gain_freeze_control),
		.gain_target_level(gain_target_level),
		.rx_sample_rate_code(4'h1),
		.rx_bandwidth_code(rx_bandwidth_code),
		.ext_amp_bypass_enable(ext_amp_bypass_enable),
		.ext_amp_gain_mapping(ext_amp_gain_mapping),
		.sw_gain_word(sw_gain_word), .bb_enable(bb_enable),
		.bb_freeze_req(bb_freeze_req), .gain_word_field(gain_word_field),
		.gain_freeze_status(gain_freeze_status),
		.gain_hold_irq(gain_hold_irq), .gain_release_irq(gain_release_irq),
		.signal_strength_field(signal_strength_field),
		.signal_strength_valid(signal_strength_valid),
		.amp_gain_word(amp_gain_word), .ext_amp_on(ext_amp_on));

	always #4 clk = ~clk;

	// Strobe every 31 cycles, close to the 4 MHz sample rate
	always @(posedge clk) begin
		cycles <= cycles + 1;
		strobe <= strobe == SP - 1 ? 0 : strobe + 1;
		sample_valid <= strobe == SP - 1;
		if (cycles == 12000) begin
			n_fail = n_fail + 1;
			print_verdict();
		end
	end

	task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			n_fail = n_fail + 1;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic apply_reset(logic [3:0] bw);
		@(posedge clk);
		rst <= 1'b1;
		rx_bandwidth_code <= bw;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		tick(1);
	endtask

	task automatic set_manual(logic [4:0] w);
		@(posedge clk);
		sw_gain_word <= w;
		tick(2);
	endtask

	task automatic wait_strength();
		lat = 0;
		while (signal_strength_valid !== 1'b1 && lat < 2000) begin
			tick(1);
			lat++;
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		apply_reset(4'hB);
		check("word_rst", {3'h0, gain_word_field}, 8'h00);
		check("strength_rst", signal_strength_field, 8'h7F);
		for (int k = 0; k < 3; k++) begin
			apply_reset(bws[k]);
			set_manual(5'h1F);
			check("gain_max", {3'h0, gain_word_field}, gmx[k]);
		end
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			ext_amp_bypass_enable <= byp[k];
			ext_amp_gain_mapping <= mp[k];
			set_manual(wd[k]);
			check("amp_map", {2'h0, ext_amp_on, amp_gain_word}, ea[k]);
		end
		set_manual(5'h0A);
		@(posedge clk);
		gain_freeze_control <= 1'b1;
		set_manual(5'h05);
		check("frozen_word", {3'h0, gain_word_field}, 8'h0A);
		check("frz_status", {7'h0, gain_freeze_status}, 8'h01);
		@(posedge clk);
		gain_freeze_control <= 1'b0;
		tick(3);
		check("released_word", {3'h0, gain_word_field}, 8'h05);
		@(posedge clk);
		bb_enable <= 1'b1;
		@(posedge clk);
		bb_freeze_req <= 1'b1;
		tick(1);
		check("hold_pulse", {7'h0, gain_hold_irq}, 8'h01);
		tick(1);
		check("hold_once", {6'h0, gain_hold_irq, gain_freeze_status}, 8'h01);
		@(posedge clk);
		bb_freeze_req <= 1'b0;
		tick(1);
		check("release_pulse", {7'h0, gain_release_irq}, 8'h01);
		// Loud filtered path, quiet unfiltered path
		set_manual(5'h0A);
		@(posedge clk);
		amp_f <= 13'sh0FA0;
		amp_u <= 13'sh0004;
		gain_loop_enable <= 1'b1;
		rx_active <= 1'b1;
		wait_strength();
		check("first_strength", {7'h0, lat >= LO && lat <= HI}, 8'h01);
		tick(1800);
		check("loud_lowers", {7'h0, gain_word_field < 5'h0A}, 8'h01);
		@(posedge clk);
		gain_freeze_control <= 1'b1;
		gain_ref_select <= 1'b1;
		tick(2);
		w0 = gain_word_field;
		s0 = signal_strength_field;
		tick(900);
		check("rx_frozen", {3'h0, gain_word_field}, {3'h0, w0});
		check("strength_moves", {7'h0, signal_strength_field != s0}, 8'h01);
		@(posedge clk);
		gain_freeze_control <= 1'b0;
		tick(1800);
		check("quiet_raises", {7'h0, gain_word_field > w0}, 8'h01);
		@(posedge clk);
		rx_active <= 1'b0;
		tick(2);
		check("strength_off", signal_strength_field, 8'h7F);
		// Filtered level that meets target 3 exactly, so the word holds
		@(posedge clk);
		gain_loop_enable <= 1'b0;
		gain_ref_select <= 1'b0;
		set_manual(5'h0A);
		@(posedge clk);
		averaging_length <= 2'h1;
		gain_target_level <= 3'h3;
		amp_f <= 13'sh012C;
		gain_loop_enable <= 1'b1;
		rx_active <= 1'b1;
		wait_strength();
		check("avg16_strength", {7'h0, lat >= LO2 && lat <= HI2}, 8'h01);
		tick(1200);
		check("target_held", {3'h0, gain_word_field}, 8'h0A);
		print_verdict();
	end
endmodule
